// ### core/sfp_control_status_pins.v
// Control and status pin logic of an optical transceiver management chip.
// Assumes one 250 MHz clock, pins passing two flip-flop synchronisers,
// and a plain register port from the management interface.
// Open-drain pins arrive as a data bit, an active-low enable and, except for
// the supply sense or irq pin, the sensed wire level; pull-ups sit outside the block.
//
// Notes on behaviour
// - Transmitter off when pin or soft bit
// - Transmit-off pin mirrored into status bit
// - Open-drain fault output, state mirrored into status
// - Enable bit selects analog sense or irq output
// - Rate output is input OR soft bit
// - Rate-select input mirrored into status bit
// - Shutdown output asserted on fault, programmable polarity
// - External fault input ORed into fault output
// - Zone bit picks internal or remote temperature
// - Five-bit trim tap for receive power
// - Photodiode range full or quarter span
// - Feedback polarity and scale from config bits
// - Signal-missing open-drain output, status mirrors pin
// - Rate output open-drain, or general-output mode
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_pins_defs.vh"

module sfp_control_status_pins (
    input  wire       sys_clk,
    input  wire       rst_b,
    // Register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Pins
    input  wire       transmit_off_input,
    input  wire       rate_select_input,
    input  wire       rx_below_threshold,
    input  wire       transmit_fault_in,
    input  wire       rx_signal_missing_in,
    input  wire       rate_select_in,
    input  wire       multifunction_in,
    output reg        transmit_disable,
    output reg        transmit_fault_out,
    output reg        transmit_fault_oe_b,
    output reg        rx_signal_missing_out,
    output reg        rx_signal_missing_oe_b,
    output reg        rate_select_out,
    output reg        rate_select_oe_b,
    output reg        multifunction_out,
    output reg        multifunction_oe_b,
    output reg        supply_sense_or_irq_out,
    output reg        supply_sense_or_irq_oe_b,
    output reg        supply_sense_analog_en,
    output reg        temp_zone_remote,
    output reg  [4:0] rx_gain_trim_tap,
    output reg        mpd_range_quarter,
    output reg        apc_feedback_invert,
    output reg  [1:0] apc_feedback_scale,
    output reg        irq
);

    // ==========================================================
    // Pin synchronisers
    // Only the second stage is read, so a metastable first stage never fans out
    localparam NSYNC = 5;
    // Status and rate output follow the rate-select input pin. The sensed
    // rate output wire is left unread: feeding it back through the OR
    // would hold the released open-drain line high for good.
    wire [NSYNC-1:0] raw_pins = {multifunction_in, rate_select_input, rx_signal_missing_in,
                                 transmit_fault_in, transmit_off_input};
    reg  [NSYNC-1:0] sync_a;
    reg  [NSYNC-1:0] sync_b;

    genvar g;
    generate
        for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sync_a[g] <= 1'b0;
                    sync_b[g] <= 1'b0;
                end else begin
                    sync_a[g] <= raw_pins[g];
                    sync_b[g] <= sync_a[g];
                end
            end
        end
    endgenerate

    wire tx_off_pin   = sync_b[0];
    wire tx_fault_pin = sync_b[1];
    wire rx_miss_pin  = sync_b[2];
    wire rate_sel_pin = sync_b[3];
    wire mf_pin       = sync_b[4];

    // rx_below_threshold comes from the on-chip comparator, same clock
    wire rx_below = rx_below_threshold;

    // ==========================================================
    // Event arming
    // Sensed open-drain pins sit at their pull-up level in reset and drop
    // once the drivers take over; that drop and the synchroniser fill
    // would otherwise post false events right after reset.
    // Limitation: a pin change inside this short window is not reported
    // as an event, though its level still shows in the status register.
    reg  [`ARM_MSB:0] arm_sr;
    wire              armed = arm_sr[`ARM_MSB];

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            arm_sr <= `RST_ARM;
        end else begin
            arm_sr <= {arm_sr[`ARM_MSB-1:0], 1'b1};
        end
    end

    // ==========================================================
    // Registers
    // Map: live pin status (read only), control, user control, vendor
    // config 1, power-control config, receive trim, general output level,
    // event status (write one to clear) and event mask. Unmapped reads
    // return zero and unmapped writes are dropped.
    reg [7:0]        control;
    reg [7:0]        user_control_register;
    reg [7:0]        vendor_config_reg1;
    reg [7:0]        apc_config;
    reg [4:0]        rx_gain_trim_pot;
    reg [7:0]        gpo_config;
    reg [`EV_MSB:0]  irq_status;
    reg [`EV_MSB:0]  irq_mask;
    reg [`EV_MSB:0]  prev_levels;

    function wr_hit;
        input [7:0] a;
        begin
            wr_hit = reg_wr && (reg_addr == a);
        end
    endfunction

    // Control register, from bit 0 upwards: soft transmit off, soft rate
    // select, internal fault source, multifunction as input, shutdown
    // polarity and rate pin in general-output mode.
    wire soft_transmit_off_bit = control[`CT_SOFT_TX_OFF];
    wire soft_rate_select_bit  = control[`CT_SOFT_RATE];
    wire mf_is_input           = control[`CT_MF_IS_INPUT];
    wire irq_output_enable     = user_control_register[`UC_IRQ_OE];

    // Pin levels mirrored continuously into status
    wire [`EV_MSB:0] levels = {rx_miss_pin, rate_sel_pin, tx_fault_pin, tx_off_pin};

    // Any level change is an interrupt event once the block is armed
    wire [`EV_MSB:0] events = (levels ^ prev_levels) & {(`EV_MSB+1){armed}};

    // ==========================================================
    // Fault and derived combinational values
    // The internal fault bit stands in for the analog fault comparators,
    // which sit outside this block.
    wire ext_fault   = mf_is_input & mf_pin;
    wire fault_any   = control[`CT_INT_FAULT] | ext_fault;
    wire next_irq    = |(irq_status & irq_mask);
    wire rate_drive  = rate_sel_pin | soft_rate_select_bit;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            control               <= `RST_BYTE;
            user_control_register <= `RST_BYTE;
            vendor_config_reg1    <= `RST_BYTE;
            apc_config            <= `RST_BYTE;
            rx_gain_trim_pot      <= `RST_TRIM;
            gpo_config            <= `RST_BYTE;
            irq_mask              <= `RST_EV;
            prev_levels           <= `RST_EV;
        end else begin
            if (wr_hit(`ADDR_CONTROL))
                control <= reg_wdata;
            if (wr_hit(`ADDR_USER_CTL))
                user_control_register <= reg_wdata;
            if (wr_hit(`ADDR_VENDOR_CFG1))
                vendor_config_reg1 <= reg_wdata;
            if (wr_hit(`ADDR_APC_CFG))
                apc_config <= reg_wdata;
            if (wr_hit(`ADDR_RX_TRIM))
                rx_gain_trim_pot <= reg_wdata[`TRIM_MSB:0];
            if (wr_hit(`ADDR_GPO_CFG))
                gpo_config <= reg_wdata;
            if (wr_hit(`ADDR_IRQ_MASK))
                irq_mask <= reg_wdata[`EV_MSB:0];
            prev_levels <= levels;
        end
    end

    // ==========================================================
    // Sticky event bits, one flop per bit, write one to clear
    // Each bit sets on a change of its pin level in either direction
    generate
        for (g = 0; g <= `EV_MSB; g = g + 1) begin : g_event
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    irq_status[g] <= 1'b0;
                end else if (events[g]) begin
                    // A new event wins over a clear in the same cycle
                    irq_status[g] <= 1'b1;
                end else if (wr_hit(`ADDR_IRQ_STAT) && reg_wdata[g]) begin
                    irq_status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read port: data valid the cycle after the strobe
    // Zero outside the read slot, so an OR-ed read bus above needs no gating
    reg [7:0] next_rdata;

    always @* begin
        next_rdata = `RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_STATUS:      next_rdata = {4'h0, levels};
                `ADDR_CONTROL:     next_rdata = control;
                `ADDR_USER_CTL:    next_rdata = user_control_register;
                `ADDR_VENDOR_CFG1: next_rdata = vendor_config_reg1;
                `ADDR_APC_CFG:     next_rdata = apc_config;
                `ADDR_RX_TRIM:     next_rdata = {3'h0, rx_gain_trim_pot};
                `ADDR_GPO_CFG:     next_rdata = gpo_config;
                `ADDR_IRQ_STAT:    next_rdata = {4'h0, irq_status};
                `ADDR_IRQ_MASK:    next_rdata = {4'h0, irq_mask};
                default:           next_rdata = `RST_BYTE;
            endcase
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= `RST_BYTE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Transmit path outputs
    // Open-drain fault: pull low while healthy, release on fault so the
    // host sees a high level through its pull-up
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            transmit_disable    <= 1'b0;
            transmit_fault_out  <= 1'b0;
            transmit_fault_oe_b <= 1'b1;
        end else begin
            transmit_disable    <= tx_off_pin | soft_transmit_off_bit;
            transmit_fault_out  <= 1'b0;
            transmit_fault_oe_b <= fault_any;
        end
    end

    // ==========================================================
    // Receive signal-missing output
    // Released, never driven high, so another circuit may wire-OR onto
    // the line; the status bit reads the sensed wire, not this flop.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_signal_missing_out  <= 1'b0;
            rx_signal_missing_oe_b <= 1'b1;
        end else begin
            rx_signal_missing_out  <= 1'b0;
            rx_signal_missing_oe_b <= rx_below;
        end
    end

    // ==========================================================
    // Rate-select output
    // Rate mode is open-drain only, so several sources may share the line;
    // general-output mode drives both levels from the stored level bit.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_select_out  <= 1'b0;
            rate_select_oe_b <= 1'b1;
        end else if (control[`CT_RS_GPO_MODE]) begin
            rate_select_out  <= gpo_config[`GPO_LEVEL];
            rate_select_oe_b <= 1'b0;
        end else begin
            rate_select_out  <= 1'b0;
            rate_select_oe_b <= rate_drive;
        end
    end

    // ==========================================================
    // Multifunction pin: shutdown output or external fault input
    // As an input the pin is released and its sensed level joins the
    // fault OR; as an output it follows the fault with selectable polarity.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            multifunction_out  <= 1'b0;
            multifunction_oe_b <= 1'b1;
        end else if (mf_is_input) begin
            multifunction_out  <= 1'b0;
            multifunction_oe_b <= 1'b1;
        end else begin
            multifunction_out  <= fault_any ^ control[`CT_LASER_SHUTDOWN_OUTPUT_POL];
            multifunction_oe_b <= 1'b0;
        end
    end

    // ==========================================================
    // Supply sense or interrupt pin
    // The converter input is enabled only while the pin is not an output,
    // so it never measures the interrupt drive.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            supply_sense_analog_en   <= 1'b1;
            supply_sense_or_irq_out  <= 1'b0;
            supply_sense_or_irq_oe_b <= 1'b1;
            irq                      <= 1'b0;
        end else begin
            supply_sense_analog_en   <= ~irq_output_enable;
            supply_sense_or_irq_out  <= 1'b0;
            supply_sense_or_irq_oe_b <= ~(irq_output_enable & next_irq);
            irq                      <= next_irq;
        end
    end

    // ==========================================================
    // Analog configuration outputs
    // Plain registered copies; the analog side treats them as static
    // settings, so no handshake guards a change.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            temp_zone_remote    <= 1'b0;
            rx_gain_trim_tap    <= `RST_TRIM;
            mpd_range_quarter   <= 1'b0;
            apc_feedback_invert <= 1'b0;
            apc_feedback_scale  <= 2'h0;
        end else begin
            temp_zone_remote    <= vendor_config_reg1[`VC_ZONE_REMOTE];
            rx_gain_trim_tap    <= rx_gain_trim_pot;
            mpd_range_quarter   <= apc_config[`APC_QUARTER];
            apc_feedback_invert <= apc_config[`APC_POL_INV];
            apc_feedback_scale  <= apc_config[`APC_SCALE_HI:`APC_SCALE_LO];
        end
    end

endmodule // sfp_control_status_pins
`default_nettype wire

// ### core/sfp_pins_defs.vh
// Constants for the transceiver control and status pin block.
// Assumes inclusion by bare name from core/ design files.
`ifndef SFP_PINS_DEFS_VH
`define SFP_PINS_DEFS_VH

// ==========================================================
// Register addresses (byte addresses, 8-bit data)
`define ADDR_STATUS      8'h00
`define ADDR_CONTROL     8'h01
`define ADDR_USER_CTL    8'h02
`define ADDR_VENDOR_CFG1 8'h03
`define ADDR_APC_CFG     8'h04
`define ADDR_RX_TRIM     8'h05
`define ADDR_GPO_CFG     8'h06
`define ADDR_IRQ_STAT    8'h07
`define ADDR_IRQ_MASK    8'h08

// ==========================================================
// Status register fields
`define ST_TX_OFF        0
`define ST_TX_FAULT      1
`define ST_RATE_SEL      2
`define ST_RX_MISSING    3

// Control register fields
`define CT_SOFT_TX_OFF   0
`define CT_SOFT_RATE     1
`define CT_INT_FAULT     2
`define CT_MF_IS_INPUT   3
`define CT_LASER_SHUTDOWN_OUTPUT_POL      4
`define CT_RS_GPO_MODE   5

// User control register field
`define UC_IRQ_OE        4

// Vendor config 1 field
`define VC_ZONE_REMOTE   0

// AUTO_POWER_CONTROL config fields
`define APC_QUARTER      0
`define APC_POL_INV      1
`define APC_SCALE_LO     2
`define APC_SCALE_HI     3

// Rx trim width
`define TRIM_MSB         4

// GENERAL_OUTPUT_MODE config field
`define GPO_LEVEL        0

// Interrupt event bit positions
`define EV_TX_OFF        0
`define EV_TX_FAULT      1
`define EV_RATE_SEL      2
`define EV_RX_MISSING    3
`define EV_MSB           3

// Reset values
`define RST_BYTE         8'h00
`define RST_TRIM         5'h10
`define RST_EV           4'h0
`define RST_ARM          4'h0

// Event detection stays off for this many edges, plus one, after reset
`define ARM_MSB          3

`endif

// ### testbench/sfp_pins_sva.sv
// Assertions on the pin block outputs.
// Assumes a bind by port name onto the block.
`timescale 1ns/1ps
`default_nettype none
module sfp_pins_sva (
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       transmit_off_input,
    input wire logic       transmit_disable,
    input wire logic       transmit_fault_out,
    input wire logic       transmit_fault_oe_b,
    input wire logic       rx_below_threshold,
    input wire logic       rx_signal_missing_oe_b,
    input wire logic       supply_sense_or_irq_out,
    input wire logic       supply_sense_or_irq_oe_b,
    input wire logic       supply_sense_analog_en,
    input wire logic       irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Pin relations; repeat counts leave margin over the synchronisers
    a_tx_off_gate: assert property (transmit_off_input[*5] |-> transmit_disable)
        else $error("transmitter not off with pin high");
    a_fault_open_drain: assert property (!transmit_fault_oe_b |-> !transmit_fault_out)
        else $error("fault pin driven high");
    a_irq_open_drain: assert property (!supply_sense_or_irq_oe_b |-> !supply_sense_or_irq_out)
        else $error("irq pin driven high");
    a_analog_quiet: assert property (supply_sense_analog_en |-> supply_sense_or_irq_oe_b)
        else $error("analog sense pin driven");
    a_rx_missing_set: assert property (rx_below_threshold[*4] |-> rx_signal_missing_oe_b)
        else $error("signal missing not released");
    a_rx_missing_clr: assert property (!rx_below_threshold[*4] |-> !rx_signal_missing_oe_b)
        else $error("signal missing not pulled low");
    a_irq_pin_low: assert property ((!supply_sense_analog_en && irq)[*3] |-> !supply_sense_or_irq_oe_b)
        else $error("pending irq not on pin");
    a_irq_pin_rel: assert property ((!supply_sense_analog_en && !irq)[*3] |-> supply_sense_or_irq_oe_b)
        else $error("irq pin held without request");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    c_tx_off: cover property (transmit_off_input ##3 transmit_disable);
    c_irq: cover property ($rose(irq));
    c_irq_pin: cover property (!supply_sense_or_irq_oe_b);
endmodule // sfp_pins_sva
`default_nettype wire

// ### testbench/sfp_host_model.sv
// Host side of the pins: pull-ups, wire-OR and an external fault source.
// Assumes oe_b low means the block drives its pin.
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
    input wire logic transmit_fault_out,
    input wire logic transmit_fault_oe_b,
    input wire logic rx_signal_missing_out,
    input wire logic rx_signal_missing_oe_b,
    input wire logic rate_select_out,
    input wire logic rate_select_oe_b,
    input wire logic multifunction_out,
    input wire logic multifunction_oe_b,
    input wire logic supply_sense_or_irq_out,
    input wire logic supply_sense_or_irq_oe_b,
    input wire logic ext_fault,
    input wire logic rx_pull_low,
    output logic     transmit_fault_in,
    output logic     rx_signal_missing_in,
    output logic     rate_select_in,
    output logic     multifunction_in,
    output logic     irq_pin
);
    // ==========================================================
    // Pull-ups win whenever the block lets go of a pin, except multifunction, which then follows ext_fault, and signal missing while rx_pull_low holds it low
    assign transmit_fault_in = transmit_fault_oe_b | transmit_fault_out;
    // Another module circuit may hold the line low
    assign rx_signal_missing_in = (rx_signal_missing_oe_b | rx_signal_missing_out) & ~rx_pull_low;
    assign rate_select_in = rate_select_oe_b | rate_select_out;
    assign multifunction_in = multifunction_oe_b ? ext_fault : multifunction_out;
    assign irq_pin = supply_sense_or_irq_oe_b | supply_sense_or_irq_out;
endmodule // sfp_host_model
`default_nettype wire

// ### testbench/sfp_control_status_pins_bench.sv
// Self-checking bench for the pin block with the host model.
// Assumes a 250 MHz clock and the register port of the block.
`timescale 1ns/1ps
`default_nettype none
module sfp_control_status_pins_bench;
    logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic transmit_off_input = 1'b0, rate_select_input = 1'b0, rx_below_threshold = 1'b0;
    logic ext_fault = 1'b0, rx_pull_low = 1'b0;
    wire  [7:0] reg_rdata;
    wire  [4:0] rx_gain_trim_tap;
    wire  [1:0] apc_feedback_scale;
    wire transmit_fault_in, rx_signal_missing_in, rate_select_in, multifunction_in, irq_pin;
    wire transmit_disable, transmit_fault_out, transmit_fault_oe_b, rx_signal_missing_out;
    wire rx_signal_missing_oe_b, rate_select_out, rate_select_oe_b, multifunction_out, multifunction_oe_b;
    wire supply_sense_or_irq_out, supply_sense_or_irq_oe_b, supply_sense_analog_en, temp_zone_remote;
    wire mpd_range_quarter, apc_feedback_invert, irq;
    int error_cnt = 0;
    int comparisons = 0;
    always #2 sys_clk = ~sys_clk;
    sfp_control_status_pins dut (.*);
    sfp_host_model host (.*);
    // ==========================================================
    // Register port and checking tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask
    // Covers the two synchroniser stages plus the output flop
    task automatic settle;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    task automatic complete_run;
        $display("Comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        settle;
        chk("trim tap", 8'h10, {3'h0, rx_gain_trim_tap});
        chk("analog sense", 8'h01, {7'h0, supply_sense_analog_en});
        rd(8'h07, 8'h00);
        wr(8'h07, 8'h0f);
        wr(8'h20, 8'hff);
        for (int i = 0; i < 10; i++) rd((i == 9) ? 8'h20 : 8'(i), (i == 5) ? 8'h10 : 8'h00);
        @(posedge sys_clk) transmit_off_input <= 1'b1;
        settle;
        chk("tx disable", 8'h01, {7'h0, transmit_disable});
        rd(8'h00, 8'h01);
        wr(8'h01, 8'h01);
        transmit_off_input <= 1'b0;
        settle;
        chk("tx disable", 8'h01, {7'h0, transmit_disable});
        rd(8'h00, 8'h00);
        wr(8'h01, 8'h04);
        settle;
        chk("tx disable", 8'h00, {7'h0, transmit_disable});
        chk("fault pin", 8'h01, {7'h0, transmit_fault_in});
        rd(8'h00, 8'h02);
        chk("shutdown", 8'h01, {7'h0, multifunction_in});
        wr(8'h01, 8'h14);
        settle;
        chk("shutdown", 8'h00, {7'h0, multifunction_in});
        wr(8'h01, 8'h08);
        ext_fault <= 1'b1;
        settle;
        chk("ext fault", 8'h01, {7'h0, transmit_fault_in});
        ext_fault <= 1'b0;
        settle;
        chk("ext fault", 8'h00, {7'h0, transmit_fault_in});
        wr(8'h01, 8'h00);
        rate_select_input <= 1'b1;
        settle;
        chk("rate pin", 8'h01, {7'h0, rate_select_in});
        rd(8'h00, 8'h04);
        wr(8'h01, 8'h02);
        rate_select_input <= 1'b0;
        settle;
        chk("rate pin", 8'h01, {7'h0, rate_select_in});
        rd(8'h00, 8'h00);
        wr(8'h06, 8'h01);
        wr(8'h01, 8'h20);
        settle;
        chk("gpo pin", 8'h01, {7'h0, rate_select_in});
        wr(8'h06, 8'h00);
        settle;
        chk("gpo pin", 8'h00, {7'h0, rate_select_in});
        wr(8'h03, 8'h01);
        wr(8'h04, 8'h0b);
        wr(8'h05, 8'h1f);
        settle;
        chk("zone", 8'h01, {7'h0, temp_zone_remote});
        chk("trim tap", 8'h1f, {3'h0, rx_gain_trim_tap});
        chk("mpd range", 8'h01, {7'h0, mpd_range_quarter});
        chk("feedback", 8'h06, {5'h0, apc_feedback_invert, apc_feedback_scale});
        wr(8'h01, 8'h00);
        wr(8'h07, 8'h0f);
        wr(8'h08, 8'h01);
        wr(8'h02, 8'h10);
        settle;
        chk("analog sense", 8'h00, {7'h0, supply_sense_analog_en});
        chk("irq pin", 8'h01, {7'h0, irq_pin});
        transmit_off_input <= 1'b1;
        settle;
        chk("irq", 8'h01, {7'h0, irq});
        chk("irq pin", 8'h00, {7'h0, irq_pin});
        rd(8'h07, 8'h01);
        wr(8'h07, 8'h01);
        settle;
        chk("irq pin", 8'h01, {7'h0, irq_pin});
        wr(8'h08, 8'h00);
        transmit_off_input <= 1'b0;
        settle;
        chk("irq masked", 8'h00, {7'h0, irq});
        rd(8'h07, 8'h01);
        rx_below_threshold <= 1'b1;
        settle;
        chk("rx missing", 8'h01, {7'h0, rx_signal_missing_in});
        rd(8'h00, 8'h08);
        rx_pull_low <= 1'b1;
        settle;
        rd(8'h00, 8'h00);
        complete_run;
    end
endmodule // sfp_control_status_pins_bench
bind sfp_control_status_pins sfp_pins_sva chk_i (.*);
`default_nettype wire
